/* common/bscx_pkg.sv */
// constants and types shared by the branch, shift and compare execution block
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - register branch goes absolute or pc-relative
// - link variants write pc into destination
// - register-form absolute and delay flag decode
// - delay slot lets next instruction complete
// - branch takes 2 cycles delayed, 3 otherwise
// - no non-delayed linking branch forms exist
// - immediate branch uses sign-extended target
// - immediate-form absolute, delay, link decode
// - immediate sign-extends unless prefix precedes
// - prefix gives upper half, field lower
// - no interrupt between prefix and user
// - register break links, jumps, sets flag, 3 cycles
// - immediate break links, jumps, sets flag
// - shift amount from low five bits
// - arithmetic right fills sign; zero unchanged
// - shifts exist only when configured; 2 cycles
// - immediate shift ignores prefix instruction
// - compare subtracts, msb shows true order
// - four stream read variants decoded
// - nonblocking sets carry; control mismatch errors
package bscx_pkg;
    localparam logic [5:0] OP_CMP     = 6'h05;
    localparam logic [5:0] OP_BS      = 6'h11;
    localparam logic [5:0] OP_BSI     = 6'h19;
    localparam logic [5:0] OP_GET     = 6'h1b;
    localparam logic [5:0] OP_BR      = 6'h26;
    localparam logic [5:0] OP_IMM     = 6'h2c;
    localparam logic [5:0] OP_BRI     = 6'h2e;
    localparam logic [4:0] BRK_FIELD  = 5'h0c;
    // field positions in lsb-0 numbering
    localparam int         OPC_LSB    = 26;
    localparam int         RD_LSB     = 21;
    localparam int         RA_LSB     = 16;
    localparam int         D_POS      = 20;
    localparam int         A_POS      = 19;
    localparam int         L_POS      = 18;
    localparam int         S_POS      = 10;
    localparam int         T_POS      = 9;
    localparam int         U_POS      = 1;
    localparam int         N_POS      = 14;
    localparam int         C_POS      = 13;
    localparam logic [1:0] CYC_ONE    = 2'h1;
    localparam logic [1:0] CYC_TWO    = 2'h2;
    localparam logic [1:0] CYC_THREE  = 2'h3;
    localparam logic       BIP_RST    = 1'h0;
    typedef enum logic [1:0] {
        BSCX_IDLE = 2'b00,
        BSCX_BUSY = 2'b01
    } bscx_state_t;
endpackage

/* hdl/bscx_exec.sv */
// execution of unconditional branch, break, barrel shift, compare, stream read decode
`timescale 1ns/1ns
`default_nettype none
module bscx_exec #(
    parameter bit USE_BARREL = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] pc,
    input  wire logic [31:0] first_src_reg,
    input  wire logic [31:0] second_src_reg,
    input  wire logic        stream_valid,
    input  wire logic        stream_ctrl,
    input  wire logic        bip_clear,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic             wr_en,
    output logic [4:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic             jump,
    output logic [31:0]      jump_target,
    output logic             delay_slot,
    output logic             irq_block,
    output logic             stream_read,
    output logic             stream_blocking,
    output logic             stream_expect_ctrl,
    output logic             carry_we,
    output logic             carry_val,
    output logic             stream_error_we,
    output logic             stream_error_val,
    output logic             break_in_progress_flag
);
    // ****************************************************************
    // decode
    // ****************************************************************
    logic [5:0]  opc;
    logic        take;
    logic        is_cmp, is_bs, is_bsi, is_get, is_br, is_bri, is_imm;
    logic        is_brk, is_brki, is_any_br;
    logic        f_abs, f_dly, f_lnk;
    logic [31:0] imm_ext;
    logic [15:0] prefix_r;
    logic        prefix_vld_r;
    logic [4:0]  sh_amt;
    logic [31:0] sh_res;
    logic [32:0] diff;
    logic        a_gt_b;
    logic        stall;
    logic [31:0] tgt_base;

    assign stall  = stream_read && stream_blocking && !stream_valid;
    assign take   = instr_valid && !busy && !stall;
    assign opc    = instr[bscx_pkg::OPC_LSB +: 6];
    assign is_cmp = opc == bscx_pkg::OP_CMP && instr[10:2] == 9'h000;
    assign is_bs  = opc == bscx_pkg::OP_BS && USE_BARREL;
    assign is_bsi = opc == bscx_pkg::OP_BSI && USE_BARREL;
    assign is_get = opc == bscx_pkg::OP_GET;
    assign is_imm = opc == bscx_pkg::OP_IMM;
    assign is_brk = opc == bscx_pkg::OP_BR
                    && instr[bscx_pkg::RA_LSB +: 5] == bscx_pkg::BRK_FIELD;
    assign is_brki = opc == bscx_pkg::OP_BRI
                    && instr[bscx_pkg::RA_LSB +: 5] == bscx_pkg::BRK_FIELD;
    // branch forms: flags from d/a/l bits; link without delay is not a form
    assign is_br  = opc == bscx_pkg::OP_BR && !is_brk
                    && !(instr[bscx_pkg::L_POS] && !instr[bscx_pkg::D_POS]);
    assign is_bri = opc == bscx_pkg::OP_BRI && !is_brki
                    && !(instr[bscx_pkg::L_POS] && !instr[bscx_pkg::D_POS]);
    assign is_any_br = is_br || is_bri;
    assign f_abs  = is_any_br && instr[bscx_pkg::A_POS];
    assign f_dly  = is_any_br && instr[bscx_pkg::D_POS];
    assign f_lnk  = is_any_br && instr[bscx_pkg::L_POS];

    // prefix: upper half from the held value, else sign extension
    assign imm_ext = prefix_vld_r ? {prefix_r, instr[15:0]}
                                  : {{16{instr[15]}}, instr[15:0]};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prefix_r     <= 16'h0000;
            prefix_vld_r <= 1'b0;
        end else if (take) begin
            prefix_r     <= instr[15:0];
            prefix_vld_r <= is_imm;  // consumed by whatever follows
        end
    end
    // the pair is atomic: interrupts held off while a prefix is pending
    assign irq_block = prefix_vld_r;

    // ****************************************************************
    // barrel shifter
    // ****************************************************************
    // immediate form uses its own 5-bit field only, prefix never applies
    assign sh_amt = is_bsi ? instr[4:0] : second_src_reg[4:0];
    always_comb begin
        if (instr[bscx_pkg::S_POS])
            sh_res = first_src_reg << sh_amt;
        else if (instr[bscx_pkg::T_POS])
            sh_res = 32'($signed(first_src_reg) >>> sh_amt);
        else
            sh_res = first_src_reg >> sh_amt;
    end

    // ****************************************************************
    // compare
    // ****************************************************************
    assign diff   = {1'b0, second_src_reg} - {1'b0, first_src_reg};
    assign a_gt_b = instr[bscx_pkg::U_POS] ? (first_src_reg > second_src_reg)
                    : ($signed(first_src_reg) > $signed(second_src_reg));

    // ****************************************************************
    // branch target
    // ****************************************************************
    always_comb begin
        tgt_base = (is_br || is_brk) ? second_src_reg : imm_ext;
        if (f_abs || is_brk || is_brki)
            jump_target = tgt_base;
        else
            jump_target = pc + tgt_base;
    end

    // ****************************************************************
    // multi-cycle occupancy
    // ****************************************************************
    bscx_pkg::bscx_state_t state_r;
    logic [1:0]            cnt_r;
    logic [1:0]            lat;
    always_comb begin
        if (is_brk || is_brki || (is_any_br && !f_dly))
            lat = bscx_pkg::CYC_THREE;
        else if (is_any_br || is_bs || is_bsi || is_get)
            lat = bscx_pkg::CYC_TWO;
        else
            lat = bscx_pkg::CYC_ONE;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= bscx_pkg::BSCX_IDLE;
            cnt_r   <= 2'h0;
        end else begin
            case (state_r)
                bscx_pkg::BSCX_IDLE: begin
                    if (take && lat != bscx_pkg::CYC_ONE) begin
                        state_r <= bscx_pkg::BSCX_BUSY;
                        cnt_r   <= 2'(lat - 2'h2);
                    end
                end
                bscx_pkg::BSCX_BUSY: begin
                    if (cnt_r == 2'h0)
                        state_r <= bscx_pkg::BSCX_IDLE;
                    else
                        cnt_r <= 2'(cnt_r - 2'h1);
                end
                default: state_r <= bscx_pkg::BSCX_IDLE;
            endcase
        end
    end
    assign busy = state_r == bscx_pkg::BSCX_BUSY;

    // ****************************************************************
    // results
    // ****************************************************************
    logic [31:0] cmp_res;
    always_comb begin
        cmp_res = diff[31:0];
        cmp_res[31] = a_gt_b;
        if (first_src_reg == second_src_reg)
            cmp_res = 32'h0000_0000;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en       <= 1'b0;
            wr_addr     <= 5'h00;
            wr_data     <= 32'h0000_0000;
            done        <= 1'b0;
            illegal     <= 1'b0;
            jump        <= 1'b0;
            delay_slot  <= 1'b0;
        end else begin
            done       <= take;
            illegal    <= take && !(is_cmp || is_bs || is_bsi || is_get || is_imm
                                   || is_any_br || is_brk || is_brki);
            jump       <= take && (is_any_br || is_brk || is_brki);
            delay_slot <= take && f_dly;
            wr_addr    <= instr[bscx_pkg::RD_LSB +: 5];
            wr_en      <= take && (f_lnk || is_brk || is_brki || is_cmp
                                   || is_bs || is_bsi || is_get);
            if (f_lnk || is_brk || is_brki)
                wr_data <= pc;
            else if (is_cmp)
                wr_data <= cmp_res;
            else if (is_bs || is_bsi)
                wr_data <= sh_res;
            else
                wr_data <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // break flag and stream read decode
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            break_in_progress_flag <= bscx_pkg::BIP_RST;
        else if (take && (is_brk || is_brki))
            break_in_progress_flag <= 1'b1;   // set wins over clear
        else if (bip_clear)
            break_in_progress_flag <= 1'b0;
    end

    assign stream_read        = instr_valid && !busy && is_get;
    assign stream_blocking    = !instr[bscx_pkg::N_POS];
    assign stream_expect_ctrl = instr[bscx_pkg::C_POS];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_we         <= 1'b0;
            carry_val        <= 1'b0;
            stream_error_we  <= 1'b0;
            stream_error_val <= 1'b0;
        end else begin
            carry_we         <= take && is_get && !stream_blocking;
            carry_val        <= !stream_valid;
            stream_error_we  <= take && is_get;
            stream_error_val <= stream_ctrl != stream_expect_ctrl;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_undelayed_br;
        take && (is_any_br && !f_dly);
    endsequence
    sequence s_busy_two;
        busy [*2] ##1 !busy;
    endsequence
    a_undelayed_three: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_undelayed_br |=> s_busy_two) else $error("undelayed branch not 3 cycles");
    a_delayed_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && f_dly |=> busy ##1 !busy) else $error("delayed branch not 2 cycles");
    a_link_pc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && f_lnk |=> wr_en && wr_data == $past(pc)) else $error("link value wrong");
    a_bip_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_brk |=> break_in_progress_flag && jump) else $error("break flag missing");
    a_cmp_equal: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_cmp && first_src_reg == second_src_reg |=> wr_data == 32'h0 && !busy)
        else $error("equal compare not zero");
    a_abs_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_br && f_abs |-> jump_target == second_src_reg)
        else $error("absolute target wrong");
    a_rel_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_bri && !f_abs && !prefix_vld_r
        |-> jump_target == pc + {{16{instr[15]}}, instr[15:0]})
        else $error("relative immediate target wrong");
    a_carry_nb: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_get && !stream_blocking |=> carry_we && carry_val == !$past(stream_valid))
        else $error("carry not inverse of valid");
    a_shift_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_bs && sh_amt == 5'h00 |=> wr_data == $past(first_src_reg))
        else $error("zero shift changed value");

    // ****************************************************************
    // further checks
    // ****************************************************************
    // the delay slot is announced together with the jump itself
    a_dly_slot_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && f_dly |=> delay_slot && jump) else $error("delay slot not flagged");
    // link without delay must never reach the jump or link path
    a_no_undly_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && opc == bscx_pkg::OP_BR && instr[bscx_pkg::L_POS] && !instr[bscx_pkg::D_POS]
        && !instr[bscx_pkg::A_POS] |=> illegal && !jump && !wr_en)
        else $error("undelayed link form accepted");
    a_lnk_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && f_lnk |-> f_dly) else $error("link without delay slot");
    a_imm_prefix_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_bri && f_abs && prefix_vld_r |-> jump_target[31:16] == prefix_r
        && jump_target[15:0] == instr[15:0]) else $error("prefix not used as upper half");
    // interrupts must wait until the prefixed instruction has been taken
    a_prefix_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_imm |=> irq_block) else $error("prefix left interruptible");
    a_brk_three: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && (is_brk || is_brki) |=> s_busy_two) else $error("break not 3 cycles");
    a_bip_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bip_clear && !(take && (is_brk || is_brki)) |=> !break_in_progress_flag)
        else $error("break flag not cleared");
    a_brki_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_brki && !prefix_vld_r |-> jump_target == {{16{instr[15]}}, instr[15:0]})
        else $error("immediate break target wrong");
    a_shift_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && (is_bs || is_bsi) |=> busy ##1 !busy) else $error("shift not 2 cycles");
    a_stream_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && is_get |=> stream_error_we
        && stream_error_val == ($past(stream_ctrl) != $past(stream_expect_ctrl)))
        else $error("stream error flag wrong");
    // a blocking read with no data must not slip through
    a_stall_get: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stall |-> !take) else $error("stalled read taken");
    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy |-> !take) else $error("instruction taken while busy");
endmodule // bscx_exec
`default_nettype wire

/* verification/tb_top.sv */
// self-checking testbench for the branch, shift and compare execution block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        ref_clk, rst_n, instr_valid, stream_valid, stream_ctrl, bip_clear;
    logic [31:0] instr, pc, first_src_reg, second_src_reg, wr_data, jump_target;
    logic        busy, done, illegal, wr_en, jump, delay_slot, irq_block;
    logic        stream_read, stream_blocking, stream_expect_ctrl, carry_we, carry_val;
    logic        stream_error_we, stream_error_val, break_in_progress_flag;
    logic [4:0]  wr_addr;
    logic [31:0] c_tgt, c_wd;
    logic [2:0]  c_dec;
    logic [8:0]  c_fl;
    int          err_count, checks, ncyc;

    bscx_exec bscx_exec_i (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .pc(pc), .first_src_reg(first_src_reg),
        .second_src_reg(second_src_reg), .stream_valid(stream_valid),
        .stream_ctrl(stream_ctrl), .bip_clear(bip_clear), .busy(busy), .done(done),
        .illegal(illegal), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .jump(jump), .jump_target(jump_target), .delay_slot(delay_slot),
        .irq_block(irq_block), .stream_read(stream_read),
        .stream_blocking(stream_blocking), .stream_expect_ctrl(stream_expect_ctrl),
        .carry_we(carry_we), .carry_val(carry_val), .stream_error_we(stream_error_we),
        .stream_error_val(stream_error_val),
        .break_in_progress_flag(break_in_progress_flag));

    // ********************************
    // shared tasks
    // ********************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waits out busy, counting the cycles the op occupies
    task automatic wait_idle();
        ncyc = 1;
        while (busy !== 1'b0) begin
            if (ncyc > 8) begin
                err_count++;
                summarize();
            end
            @(posedge ref_clk);
            #1;
            ncyc++;
        end
    endtask

    task automatic run_op(input logic [31:0] ins, input logic [31:0] p,
                          input logic [31:0] a, input logic [31:0] b,
                          input logic sv, input logic sc);
        @(posedge ref_clk);
        instr_valid <= 1'h1;
        instr <= ins;
        pc <= p;
        first_src_reg <= a;
        second_src_reg <= b;
        stream_valid <= sv;
        stream_ctrl <= sc;
        #1;
        c_dec = {stream_read, stream_blocking, stream_expect_ctrl};
        c_tgt = jump_target;
        @(posedge ref_clk);
        instr_valid <= 1'h0;
        #1;
        c_fl = {done, jump, wr_en, delay_slot, illegal, carry_we, carry_val,
                stream_error_we, stream_error_val};
        c_wd = wr_data;
        wait_idle();
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_branch();
        logic [2:0]  fl [6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h5, 3'h7};
        logic [31:0] opnd;
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 6; k++) begin
                opnd = f ? 32'hffff_fff0 : 32'h0000_0100;
                run_op({(f ? bscx_pkg::OP_BRI : bscx_pkg::OP_BR), 5'h03, fl[k], 2'h0,
                        (f ? 16'hfff0 : 16'h0000)}, 32'h0000_1000, 32'h0, opnd, 1'h1, 1'(f));
                chk(c_tgt, fl[k][1] ? opnd : 32'h0000_1000 + opnd);
                chk(32'(c_fl), 32'({3'h6 | fl[k][0], fl[k][2], 5'h0}));
                chk(32'(ncyc), fl[k][2] ? 32'h2 : 32'h3);
                if (fl[k][0]) chk(c_wd, 32'h0000_1000);
            end
        end
        $display("test branch finished");
    endtask

    task automatic t_illegal();
        logic [31:0] ins [5] = '{{bscx_pkg::OP_BR, 5'h03, 5'h04, 16'h0},
            {bscx_pkg::OP_CMP, 26'h000_0004},
            {bscx_pkg::OP_BRI, 5'h03, 5'h04, 16'h0010},
            {bscx_pkg::OP_BRI, 5'h03, 5'h05, 16'h0010}, {6'h3f, 26'h0}};
        for (int k = 0; k < 5; k++) begin
            run_op(ins[k], 32'h0000_2000, 32'h0, 32'h40, 1'h1, 1'h0);
            chk(32'({c_fl[7], c_fl[6], c_fl[4]}), 32'h1);
        end
        $display("test illegal finished");
    endtask

    task automatic t_break();
        run_op({bscx_pkg::OP_BR, 5'h05, bscx_pkg::BRK_FIELD, 16'h0}, 32'h0000_2000,
               32'h0, 32'h0000_0200, 1'h1, 1'h0);
        chk(c_tgt, 32'h0000_0200);
        chk({c_wd[27:0], 3'(ncyc), break_in_progress_flag}, {28'h0002000, 3'h3, 1'h1});
        @(posedge ref_clk);
        bip_clear <= 1'h1;
        @(posedge ref_clk);
        bip_clear <= 1'h0;
        #1;
        chk(32'(break_in_progress_flag), 32'h0);
        run_op({bscx_pkg::OP_BRI, 5'h05, bscx_pkg::BRK_FIELD, 16'h8000}, 32'h0000_3000,
               32'h0, 32'h0, 1'h1, 1'h0);
        chk(c_tgt, 32'hffff_8000);
        chk({c_wd[27:0], c_fl[6], 2'(ncyc), break_in_progress_flag},
            {28'h0003000, 1'h1, 2'h3, 1'h1});
        $display("test break finished");
    endtask

    task automatic t_prefix();
        run_op({bscx_pkg::OP_IMM, 10'h0, 16'h1234}, 32'h100, 32'h0, 32'h0, 1'h1, 1'h0);
        chk(32'(irq_block), 32'h1);
        run_op({bscx_pkg::OP_BRI, 5'h00, 5'h08, 16'h5678}, 32'h104, 32'h0, 32'h0, 1'h1, 1'h0);
        chk(c_tgt, 32'h1234_5678);
        chk(32'(irq_block), 32'h0);
        run_op({bscx_pkg::OP_IMM, 10'h0, 16'hffff}, 32'h108, 32'h0, 32'h0, 1'h1, 1'h0);
        run_op({bscx_pkg::OP_BSI, 10'h0e1, 16'h0404}, 32'h10c, 32'h0000_00f1, 32'h0, 1'h1, 1'h0);
        chk(c_wd, 32'h0000_0f10);
        $display("test prefix finished");
    endtask

    task automatic t_shift();
        logic [31:0] ins [7] = '{32'h44e1_1400, 32'h44e1_1000, 32'h44e1_1200, 32'h44e1_1200,
                                 32'h64e1_0404, 32'h64e1_021f, 32'h64e1_001f};
        logic [31:0] b [7] = '{32'hffff_ffe4, 32'h4, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] e [7] = '{32'h0000_0f10, 32'h0800_000f, 32'hf800_000f, 32'h8000_00f1,
                               32'h0000_0f10, 32'hffff_ffff, 32'h0000_0001};
        for (int k = 0; k < 7; k++) begin
            run_op(ins[k], 32'h0, 32'h8000_00f1, b[k], 1'h1, 1'h0);
            chk(c_wd, e[k]);
            chk(32'({c_fl[6], 2'(ncyc)}), 32'h6);
        end
        $display("test shift finished");
    endtask

    task automatic t_cmp();
        logic [31:0] a [3] = '{32'h5, 32'hffff_ffff, 32'h1};
        logic [31:0] b [3] = '{32'h5, 32'h1, 32'hffff_ffff};
        logic [31:0] d;
        logic        gt;
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 3; k++) begin
                d = b[k] - a[k];
                gt = u ? (a[k] > b[k]) : ($signed(a[k]) > $signed(b[k]));
                run_op(32'h14e1_1000 | 32'(u << bscx_pkg::U_POS), 32'h0, a[k], b[k], 1'h1, 1'h0);
                chk(c_wd, (a[k] == b[k]) ? 32'h0 : {gt, d[30:0]});
                chk(32'(ncyc), 32'h1);
            end
        end
        $display("test compare finished");
    endtask

    task automatic t_stream();
        logic [31:0] ins;
        logic        v;
        for (int n = 0; n < 2; n++) begin
            for (int c = 0; c < 2; c++) begin
                ins = 32'h6d40_0000 | 32'(n << bscx_pkg::N_POS) | 32'(c << bscx_pkg::C_POS);
                v = !(n == 1 && c == 1);
                run_op(ins, 32'h0, 32'h0, 32'h0, v, 1'(n));
                chk(32'(c_dec), 32'({1'h1, 1'(!n), 1'(c)}));
                chk(32'(c_fl & (n ? 9'h1ff : 9'h1fb)),
                    32'({1'h1, 4'h4, 1'(n), 1'(n == 1 && !v), 1'h1, 1'(n != c)}));
            end
        end
        // a blocking read waits for valid data before it is taken
        @(posedge ref_clk);
        instr_valid <= 1'h1;
        instr <= 32'h6d40_0000;
        stream_valid <= 1'h0;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            chk(32'(done), 32'h0);
        end
        @(posedge ref_clk);
        stream_valid <= 1'h1;
        @(posedge ref_clk);
        instr_valid <= 1'h0;
        #1;
        chk(32'(done), 32'h1);
        wait_idle();
        $display("test stream finished");
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        {rst_n, instr_valid, stream_valid, stream_ctrl, bip_clear} = 5'h0;
        {instr, pc, first_src_reg, second_src_reg} = 128'h0;
        err_count = 0;
        checks = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_branch();
        t_illegal();
        t_break();
        t_prefix();
        t_shift();
        t_cmp();
        t_stream();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
